// >>> verilog/cache_part_pkg.sv
// Constants for the cache partition allocation control block.
// Assumes one clock domain and a plain register port from software.
package cache_part_pkg;
	// ---------------------------------------------------------------
	// Geometry
	// ---------------------------------------------------------------
	localparam int PART_COUNT = 16;
	localparam int PART_W = 4;
	localparam int PORTION_COUNT = 8;
	localparam int PORTION_W = 3;
	localparam int LINE_COUNT = 1024;
	localparam int OCC_W = 11;
	localparam int LIMIT_W = 16;
	localparam int LIMIT_IMPL_BITS = 8;
	localparam logic [15:0] LIMIT_KEEP_MASK = 16'hFF00;
	localparam logic [15:0] LIMIT_RESET = 16'hFFFF;
	localparam logic [7:0] PORTION_MAP_RESET = 8'hFF;
	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] FEATURE_ID_OFS = 8'h00;
	localparam logic [7:0] PORTION_COUNT_ID_OFS = 8'h04;
	localparam logic [7:0] PARTITION_SELECT_OFS = 8'h08;
	localparam logic [7:0] PORTION_ALLOW_OFS = 8'h0C;
	localparam logic [7:0] CAPACITY_LIMIT_OFS = 8'h10;
	localparam logic [7:0] OCCUPANCY_OFS = 8'h14;
	// ---------------------------------------------------------------
	// Feature id fields
	// ---------------------------------------------------------------
	localparam int FEAT_PORTION_BIT = 0;
	localparam int FEAT_CAPACITY_BIT = 1;
	localparam int COUNT_FIELD_W = 16;
endpackage : cache_part_pkg

// >>> verilog/cache_partition_allocation_control.sv
// Allocation gate for a partitioned cache: per partition portion map,
// capacity limit and occupancy count. Assumes the cache presents each
// install request and each eviction with the owning partition tag.
// Notes on behaviour
// - Portion and capacity controls are each optional via parameters.
// - Feature id register shows a presence bit for each control.
// - Config writes go to the partition held in the select register.
// - Portions are equal fixed slices; their count is a constant.
// - A portion enabled for several partitions is open to all of them.
// - Victim choice is restricted to portions allowed for the request.
// - Each map bit allows or forbids one capacity portion.
// - Map width equals portion count, readable in the count id register.
// - Map changes touch only later installs; nothing is evicted.
// - Lines in disallowed portions stay valid until normal replacement.
// - With both controls, an install needs an allowed portion and headroom, or an own victim in an allowed portion.
// - At or above its limit a partition may not grow on installs.
// - Over limit, the install is skipped or replaces own-partition data.
// - Lookups ignore partitions; hit reporting passes through unchanged.
// - Capacity limit is a per partition fraction of total capacity.
// - All-ones sixteen bits stands for the whole cache.
// - Low limit bits are not stored and read back as zero.
// - Enforcement lies between stored value and one low unit above.
`timescale 1ns/1ps
module cache_partition_allocation_control
	import cache_part_pkg::*;
#(
	parameter bit HAS_PORTION = 1'b1, // Portion control built
	parameter bit HAS_CAPACITY = 1'b1 // Capacity control built
) (
	input wire logic sys_clk, // System clock
	input wire logic rst, // Synchronous reset, high
	input wire logic [ADDR_W-1:0] reg_addr, // Register byte address
	input wire logic [31:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [31:0] reg_rdata, // Read data, cycle after strobe
	input wire logic alloc_req, // Install request
	input wire logic [PART_W-1:0] alloc_partition, // Partition of request
	input wire logic [PORTION_COUNT-1:0] alloc_own_victim, // Portion victim owned by it
	output logic alloc_grant, // Install permitted
	output logic [PORTION_COUNT-1:0] alloc_portion_mask, // Portions allowed
	output logic alloc_replace_own, // Must evict own line
	input wire logic install_done, // Line installed
	input wire logic [PART_W-1:0] install_partition, // Owner of new line
	input wire logic evict_done, // Line evicted
	input wire logic [PART_W-1:0] evict_partition, // Owner of removed line
	input wire logic lookup_hit_in, // Cache hit
	output logic lookup_hit_out // Hit, unaffected by partitions
);
	// ---------------------------------------------------------------
	// Configuration storage
	// ---------------------------------------------------------------
	logic [PART_W-1:0] select_q;
	logic [PORTION_COUNT-1:0] map_q [PART_COUNT];
	logic [LIMIT_W-1:0] limit_q [PART_COUNT];
	logic [OCC_W-1:0] occ_q [PART_COUNT];
	logic [PORTION_COUNT-1:0] map_eff;
	logic at_limit;
	logic [LIMIT_W+OCC_W-1:0] scaled_limit;
	logic [31:0] rdata_d;
	logic [31:0] rdata_q;

	// Partition select register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			select_q <= '0;
		end else if (reg_wr && reg_addr == PARTITION_SELECT_OFS) begin
			select_q <= reg_wdata[PART_W-1:0];
		end
	end

	// Per partition controls; low limit bits are dropped on write
	generate
		for (genvar p = 0; p < PART_COUNT; p++) begin : g_part
			always_ff @(posedge sys_clk) begin
				if (rst) begin
					map_q[p] <= PORTION_MAP_RESET;
					limit_q[p] <= LIMIT_RESET & LIMIT_KEEP_MASK;
				end else if (reg_wr && select_q == PART_W'(p)) begin
					if (reg_addr == PORTION_ALLOW_OFS && HAS_PORTION) begin
						map_q[p] <= reg_wdata[PORTION_COUNT-1:0];
					end
					if (reg_addr == CAPACITY_LIMIT_OFS && HAS_CAPACITY) begin
						limit_q[p] <= reg_wdata[LIMIT_W-1:0] & LIMIT_KEEP_MASK;
					end
				end
			end

			// Occupancy; install and evict in one cycle cancel out
			always_ff @(posedge sys_clk) begin
				if (rst) begin
					occ_q[p] <= '0;
				end else begin
					case ({install_done && install_partition == PART_W'(p),
						evict_done && evict_partition == PART_W'(p)})
						2'b10: occ_q[p] <= occ_q[p] + OCC_W'(1);
						2'b01: occ_q[p] <= occ_q[p] - OCC_W'(1);
						default: occ_q[p] <= occ_q[p];
					endcase
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Allocation decision
	// ---------------------------------------------------------------
	// Map applies only to new installs; resident lines are never moved
	assign map_eff = HAS_PORTION ? map_q[alloc_partition] : '1;
	// Stored limit 0xFF00*LINES>>16 gives 1020, just under LINES, erring inside the interval
	assign scaled_limit = (LIMIT_W+OCC_W)'(limit_q[alloc_partition]) *
		(LIMIT_W+OCC_W)'(LINE_COUNT);
	assign at_limit = HAS_CAPACITY &&
		({5'h00, occ_q[alloc_partition]} >= scaled_limit[LIMIT_W+OCC_W-1:LIMIT_W]);

	// Over limit: only a victim line of the same partition may be replaced
	always_comb begin
		alloc_portion_mask = '0;
		alloc_grant = 1'b0;
		alloc_replace_own = 1'b0;
		if (alloc_req) begin
			if (at_limit) begin
				alloc_portion_mask = map_eff & alloc_own_victim;
				alloc_replace_own = |alloc_portion_mask;
			end else begin
				alloc_portion_mask = map_eff;
			end
			alloc_grant = |alloc_portion_mask;
		end
	end

	// Lookups pass straight through
	assign lookup_hit_out = lookup_hit_in;

	// ---------------------------------------------------------------
	// Register read
	// ---------------------------------------------------------------
	always_comb begin
		rdata_d = 32'h0000_0000;
		case (reg_addr)
			FEATURE_ID_OFS: begin
				rdata_d[FEAT_PORTION_BIT] = HAS_PORTION;
				rdata_d[FEAT_CAPACITY_BIT] = HAS_CAPACITY;
			end
			PORTION_COUNT_ID_OFS: rdata_d[COUNT_FIELD_W-1:0] =
				COUNT_FIELD_W'(PORTION_COUNT);
			PARTITION_SELECT_OFS: rdata_d[PART_W-1:0] = select_q;
			PORTION_ALLOW_OFS: rdata_d[PORTION_COUNT-1:0] =
				HAS_PORTION ? map_q[select_q] : '0;
			CAPACITY_LIMIT_OFS: rdata_d[LIMIT_W-1:0] =
				HAS_CAPACITY ? limit_q[select_q] : '0;
			OCCUPANCY_OFS: rdata_d[OCC_W-1:0] = occ_q[select_q];
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= reg_rd ? rdata_d : 32'h0000_0000;
		end
	end
	assign reg_rdata = rdata_q;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_select_write: assert property (@(posedge sys_clk) disable iff (rst)
		reg_wr && reg_addr == PARTITION_SELECT_OFS |=> select_q == $past(reg_wdata[PART_W-1:0]))
		else $error("select not captured");
	a_map_respect: assert property (@(posedge sys_clk) disable iff (rst)
		alloc_req |-> (alloc_portion_mask & ~map_eff) == '0)
		else $error("install outside allowed portions");
	a_zero_map: assert property (@(posedge sys_clk) disable iff (rst)
		alloc_req && map_eff == '0 |-> !alloc_grant)
		else $error("zero map granted");
	a_limit_block: assert property (@(posedge sys_clk) disable iff (rst)
		alloc_req && at_limit && alloc_grant |-> alloc_replace_own)
		else $error("growth past limit");
	a_occ_install: assert property (@(posedge sys_clk) disable iff (rst)
		install_done && !evict_done |=>
		occ_q[$past(install_partition)] == $past(occ_q[install_partition]) + OCC_W'(1))
		else $error("occupancy not counted up");
	a_limit_trunc: assert property (@(posedge sys_clk) disable iff (rst)
		(limit_q[select_q] & ~LIMIT_KEEP_MASK) == '0)
		else $error("low limit bits stored");
	a_read_timing: assert property (@(posedge sys_clk) disable iff (rst)
		reg_rd && reg_addr == PORTION_COUNT_ID_OFS |=> reg_rdata == 32'(PORTION_COUNT))
		else $error("portion count read wrong");
	a_hit_pass: assert property (@(posedge sys_clk) disable iff (rst)
		lookup_hit_out == lookup_hit_in)
		else $error("lookup altered");
	a_read_idle: assert property (@(posedge sys_clk) disable iff (rst)
		!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data outside slot");
endmodule : cache_partition_allocation_control

// >>> verif/requester_model.sv
// Upstream requester model: install requests, install/evict reports, hits.
// Assumes the bench calls its tasks; each lowers its strobes one edge later.
`timescale 1ns/1ps
module requester_model
	import cache_part_pkg::*;
(
	input wire logic sys_clk, // System clock
	output logic alloc_req = 1'b0, // Install request
	output logic [PART_W-1:0] alloc_partition = '0, // Requesting partition
	output logic [PORTION_COUNT-1:0] alloc_own_victim = '0, // Own victims
	output logic install_done = 1'b0, // Install pulse
	output logic [PART_W-1:0] install_partition = '0, // New line owner
	output logic evict_done = 1'b0, // Evict pulse
	output logic [PART_W-1:0] evict_partition = '0, // Removed line owner
	output logic lookup_hit_in = 1'b0 // Hit from tag array
);
	// Request held until sampled; released tags inverted so stale ones never match
	task automatic alloc(input logic [3:0] p, input logic [7:0] own);
		@(posedge sys_clk);
		alloc_req <= 1'b1;
		alloc_partition <= p;
		alloc_own_victim <= own;
		@(negedge sys_clk);
		@(posedge sys_clk);
		alloc_req <= 1'b0;
		alloc_partition <= ~p;
		alloc_own_victim <= ~own;
	endtask : alloc
	// One install (inst=1) or eviction report for partition p
	task automatic count(input logic inst, input logic [3:0] p);
		@(posedge sys_clk);
		install_done <= inst;
		evict_done <= !inst;
		install_partition <= p;
		evict_partition <= p;
		@(posedge sys_clk);
		install_done <= 1'b0;
		evict_done <= 1'b0;
		install_partition <= ~p;
		evict_partition <= ~p;
	endtask : count
endmodule : requester_model

// >>> verif/cache_partition_allocation_control_test.sv
// Self-checking bench for the cache partition allocation gate.
// Assumes the requester model and the design package are compiled first.
`timescale 1ns/1ps
module cache_partition_allocation_control_test import cache_part_pkg::*;;
	logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = '0, map;
	logic [31:0] reg_wdata = '0, reg_rdata, seed = 32'd75, r;
	logic alloc_req, alloc_grant, alloc_replace_own, install_done, evict_done;
	logic lookup_hit_in, lookup_hit_out;
	logic [3:0] alloc_partition, install_partition, evict_partition, p;
	logic [7:0] alloc_own_victim, alloc_portion_mask, own, maps [16];
	logic [15:0] lim;
	logic [8:0] e;
	int num_errors = 0, checked = 0;
	always #5 sys_clk = ~sys_clk;
	requester_model req (.sys_clk(sys_clk), .alloc_req(alloc_req),
		.alloc_partition(alloc_partition), .alloc_own_victim(alloc_own_victim),
		.install_done(install_done), .install_partition(install_partition),
		.evict_done(evict_done), .evict_partition(evict_partition),
		.lookup_hit_in(lookup_hit_in));
	cache_partition_allocation_control uut (.sys_clk(sys_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .alloc_req(alloc_req), .alloc_partition(alloc_partition),
		.alloc_own_victim(alloc_own_victim), .alloc_grant(alloc_grant),
		.alloc_portion_mask(alloc_portion_mask), .alloc_replace_own(alloc_replace_own),
		.install_done(install_done), .install_partition(install_partition),
		.evict_done(evict_done), .evict_partition(evict_partition),
		.lookup_hit_in(lookup_hit_in), .lookup_hit_out(lookup_hit_out));
	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	function automatic logic [31:0] xorshift();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xorshift
	// {at limit, allowed portions}; limit scaled by line count
	function automatic logic [8:0] gate(input logic [7:0] m, input logic [15:0] l,
		input int occ, input logic [7:0] o);
		logic at;
		at = occ >= ((int'(l & LIMIT_KEEP_MASK) * LINE_COUNT) >>> 16);
		return {at, at ? (m & o) : m};
	endfunction : gate
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		check(reg_rdata, x);
	endtask : rd
	// Grant, mask and own-replace are combinational: sampled mid-cycle
	task automatic ac(input logic [3:0] q, input logic [7:0] o, input logic [8:0] x);
		fork
			req.alloc(q, o);
			begin
				// Request is launched at the next rising edge; look mid-cycle after it
				@(posedge sys_clk);
				@(negedge sys_clk);
				check({alloc_replace_own, alloc_grant, alloc_portion_mask},
					{x[8] & |x[7:0], |x[7:0], x[7:0]});
			end
		join
	endtask : ac
	task automatic final_report();
		if (num_errors == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report
	// Watchdog well beyond the few hundred cycles the sequence needs
	initial begin
		#500000;
		num_errors++;
		final_report();
	end
	initial begin
		foreach (maps[k]) maps[k] = PORTION_MAP_RESET;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		rd(FEATURE_ID_OFS, 32'h3);
		rd(PORTION_COUNT_ID_OFS, 32'(PORTION_COUNT));
		rd(CAPACITY_LIMIT_OFS, 32'(LIMIT_RESET & LIMIT_KEEP_MASK));
		wr(8'h20, 32'h5A5A5A5A);
		rd(8'h20, 32'h0);
		wr(PORTION_COUNT_ID_OFS, 32'h0);
		rd(PORTION_COUNT_ID_OFS, 32'(PORTION_COUNT));
		// Random programming; first two passes are the zero-map and full-limit corners
		for (int i = 0; i < 24; i++) begin
			r = xorshift();
			p = (r[3:0] == 4'h5) ? 4'h6 : r[3:0];
			map = (i == 0) ? 8'h00 : r[11:4];
			lim = (i == 1) ? 16'hFFFF : r[27:12];
			own = 8'(xorshift());
			maps[p] = map;
			wr(PARTITION_SELECT_OFS, 32'(p));
			wr(PORTION_ALLOW_OFS, 32'(map));
			wr(CAPACITY_LIMIT_OFS, 32'(lim));
			rd(CAPACITY_LIMIT_OFS, 32'(lim & LIMIT_KEEP_MASK));
			ac(p, own, gate(map, lim, 0, own));
		end
		// Partition 5: four-line limit, fill, over-limit replacement, evict
		wr(PARTITION_SELECT_OFS, 32'h5);
		wr(PORTION_ALLOW_OFS, 32'h0F);
		wr(CAPACITY_LIMIT_OFS, 32'h0100);
		ac(4'h5, 8'hF0, gate(8'h0F, 16'h0100, 0, 8'hF0));
		repeat (4) req.count(1'b1, 4'h5);
		req.count(1'b1, 4'h6);
		rd(OCCUPANCY_OFS, 32'h4);
		ac(4'h5, 8'h3C, 9'h10C);
		ac(4'h5, 8'hF0, 9'h100);
		wr(PORTION_ALLOW_OFS, 32'h03);
		maps[5] = 8'h03;
		rd(OCCUPANCY_OFS, 32'h4);
		req.count(1'b0, 4'h5);
		rd(OCCUPANCY_OFS, 32'h3);
		ac(4'h5, 8'h00, 9'h003);
		// Hit passes regardless of partition state
		for (int v = 0; v < 2; v++) begin
			@(posedge sys_clk);
			req.lookup_hit_in <= v[0];
			@(negedge sys_clk);
			check(32'(lookup_hit_out), 32'(v));
		end
		foreach (maps[k]) begin
			wr(PARTITION_SELECT_OFS, 32'(k));
			rd(PORTION_ALLOW_OFS, 32'(maps[k]));
		end
		final_report();
	end
endmodule : cache_partition_allocation_control_test
